// ### verilog/umcl_top.v
// per-channel modem control and line status registers of a uart channel
`timescale 1ns/10ps
`default_nettype none
`include "umcl_consts.vh"
module umcl_top
#(
  parameter DEPTH = `UMCL_FIFO_DEPTH,
  parameter AW = `UMCL_FIFO_AW
)
(
  input wire sys_clk,
  input wire srst,
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire feat_wr_en,
  input wire rx_hold_rd,
  output reg [7:0] rx_hold_data,
  input wire rx_char_valid,
  input wire [7:0] rx_char,
  input wire rx_break,
  input wire rx_framing,
  input wire rx_parity,
  input wire tx_hold_empty,
  input wire tx_shift_empty,
  input wire tx_serial,
  input wire rx_pin,
  output reg rx_serial,
  input wire cts_n_pin,
  output reg cts_status,
  output reg dsr_status_loop,
  input wire auto_rts_en,
  input wire auto_rts_n,
  output reg rts_n_pin,
  input wire dtr_pin_sel,
  input wire pin_level_dtr,
  output reg dtr_n_pin,
  output reg baud_tick,
  output reg ir_mode,
  output reg xon_any,
  output reg trig_regs_en,
  output reg loopback
);
  localparam W = `UMCL_CHAR_W + `UMCL_FLAG_W;

  // =====================================================================
  // register index decode, shared by the write and read paths
  function hit;
    input [2:0] addr;
    input [2:0] idx;
    begin
      hit = (addr == idx);
    end
  endfunction

  // =====================================================================
  // modem control register
  reg [7:0] modem_control_register;
  wire wr_mctl;
  wire [7:0] mctl_mask;
  wire [7:0] next_mctl;
  assign wr_mctl = reg_wr && hit(reg_addr, `UMCL_ADDR_MODEM_CTL);
  // gated bits keep their value unless the feature write enable is up;
  // reserved bit 3 is never written, so it always reads back zero
  assign mctl_mask = feat_wr_en ? `UMCL_MCTL_WR_MASK :
    (`UMCL_MCTL_WR_MASK & ~`UMCL_MCTL_GATED_MASK);
  assign next_mctl = (reg_wdata & mctl_mask) | (modem_control_register & ~mctl_mask);
  always @(posedge sys_clk)
  begin
    if (srst)
      modem_control_register <= `UMCL_MCTL_RESET;
    else if (wr_mctl)
      modem_control_register <= next_mctl;
  end

  // single-bit views of the control fields
  wire clk_div4;
  wire ir_sel;
  wire any_resume;
  wire trig_sel;
  wire loop_on;
  wire rts_bit;
  wire dtr_bit;
  assign clk_div4 = modem_control_register[`UMCL_MCTL_CLKDIV];
  assign ir_sel = modem_control_register[`UMCL_MCTL_IRMODE];
  assign any_resume = modem_control_register[`UMCL_MCTL_XANY];
  assign trig_sel = modem_control_register[`UMCL_MCTL_TRIGEN];
  assign loop_on = modem_control_register[`UMCL_MCTL_LOOP];
  assign rts_bit = modem_control_register[`UMCL_MCTL_RTS];
  assign dtr_bit = modem_control_register[`UMCL_MCTL_DTR];

  // =====================================================================
  // prescaler
  wire pre_tick;
  umcl_prescaler u_pre
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .div4(clk_div4),
    .tick(pre_tick)
  );

  // =====================================================================
  // receive fifo with per-character error flags
  wire [W-1:0] rx_entry;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [W-1:0] fifo_out;
  wire [DEPTH-1:0] slot_used;
  wire [DEPTH*W-1:0] slot_data;
  wire fifo_pop;
  wire stat_rd;
  wire overrun_evt;
  reg overrun;
  assign fifo_pop = rx_hold_rd && fifo_out_valid;
  assign stat_rd = reg_rd && hit(reg_addr, `UMCL_ADDR_LINE_STAT);
  // a break stores a zero character whatever the receiver assembled
  assign rx_entry = {rx_break, rx_framing, rx_parity, rx_break ? 8'h00 : rx_char};
  // a full fifo refuses the character, which is the overrun
  assign overrun_evt = rx_char_valid && !fifo_in_ready;
  umcl_fifo
  #(
    .WIDTH(W),
    .DEPTH(DEPTH),
    .AW(AW)
  )
  u_fifo
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(rx_char_valid),
    .in_ready(fifo_in_ready),
    .in_data(rx_entry),
    .out_valid(fifo_out_valid),
    .out_ready(rx_hold_rd),
    .out_data(fifo_out),
    .slot_used(slot_used),
    .slot_data(slot_data)
  );

  // =====================================================================
  // error summary over every occupied slot
  wire [DEPTH-1:0] slot_err;
  wire any_err;
  genvar s;
  generate
    for (s = 0; s < DEPTH; s = s + 1)
    begin : err_scan
      assign slot_err[s] = slot_used[s] &&
        (slot_data[s*W+`UMCL_FLAG_LSB +: `UMCL_FLAG_W] != {`UMCL_FLAG_W{1'b0}});
    end
  endgenerate
  assign any_err = |slot_err;
  // flags of the character that the next data read will return
  wire [`UMCL_FLAG_W-1:0] head_flags;
  assign head_flags = fifo_out_valid ? fifo_out[W-1:`UMCL_FLAG_LSB] :
    {`UMCL_FLAG_W{1'b0}};

  // =====================================================================
  // overrun: a drop and a status read in one cycle keep the flag,
  // so the host never loses an overrun that it has not yet seen
  always @(posedge sys_clk)
  begin
    if (srst)
      overrun <= 1'b0;
    else if (overrun_evt)
      overrun <= 1'b1;
    else if (stat_rd)
      overrun <= 1'b0;
  end

  // =====================================================================
  // line status register
  wire [7:0] line_status_register;
  assign line_status_register = {
    any_err,
    tx_hold_empty && tx_shift_empty,
    tx_hold_empty,
    head_flags,
    overrun,
    fifo_out_valid
  };

  // =====================================================================
  // register read port; the host reads status before the data
  always @(posedge sys_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (hit(reg_addr, `UMCL_ADDR_MODEM_CTL))
        reg_rdata <= modem_control_register;
      else if (hit(reg_addr, `UMCL_ADDR_LINE_STAT))
        reg_rdata <= line_status_register;
      else
        reg_rdata <= 8'h00;
    end
  end

  // popped character, held until the next pop
  always @(posedge sys_clk)
  begin
    if (srst)
      rx_hold_data <= 8'h00;
    else if (fifo_pop)
      rx_hold_data <= fifo_out[`UMCL_CHAR_W-1:0];
  end

  // =====================================================================
  // mode outputs, one register each
  always @(posedge sys_clk)
  begin
    if (srst)
      baud_tick <= 1'b0;
    else
      baud_tick <= pre_tick;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      ir_mode <= 1'b0;
    else
      ir_mode <= ir_sel;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      xon_any <= 1'b0;
    else
      xon_any <= any_resume;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      trig_regs_en <= 1'b0;
    else
      trig_regs_en <= trig_sel;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      loopback <= 1'b0;
    else
      loopback <= loop_on;
  end

  // =====================================================================
  // modem pins and loopback paths
  reg next_rx_serial;
  reg next_cts_status;
  reg next_dsr_status;
  reg next_rts_n;
  reg next_dtr_n;
  // in loopback the modem outputs stay inactive toward the line
  always @*
  begin
    next_rx_serial = rx_pin;
    next_cts_status = ~cts_n_pin;
    next_dsr_status = 1'b0;
    next_rts_n = ~rts_bit;
    next_dtr_n = pin_level_dtr;
    if (auto_rts_en)
      next_rts_n = auto_rts_n;
    if (dtr_pin_sel)
      next_dtr_n = ~dtr_bit;
    if (loop_on)
    begin
      next_rx_serial = tx_serial;
      next_cts_status = rts_bit;
      next_dsr_status = dtr_bit;
      next_rts_n = 1'b1;
      next_dtr_n = 1'b1;
    end
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      rx_serial <= 1'b1;
    else
      rx_serial <= next_rx_serial;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      cts_status <= 1'b0;
    else
      cts_status <= next_cts_status;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      dsr_status_loop <= 1'b0;
    else
      dsr_status_loop <= next_dsr_status;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      rts_n_pin <= 1'b1;
    else
      rts_n_pin <= next_rts_n;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      dtr_n_pin <= 1'b1;
    else
      dtr_n_pin <= next_dtr_n;
  end
endmodule
`default_nettype wire

// ### verilog/umcl_consts.vh
// register offsets, bit positions and reset values of the modem control / line status block
`ifndef UMCL_CONSTS_VH
`define UMCL_CONSTS_VH
`define UMCL_ADDR_MODEM_CTL 3'h4
`define UMCL_ADDR_LINE_STAT 3'h5
`define UMCL_MCTL_RESET 8'h00
`define UMCL_MCTL_CLKDIV 7
`define UMCL_MCTL_IRMODE 6
`define UMCL_MCTL_XANY 5
`define UMCL_MCTL_LOOP 4
`define UMCL_MCTL_TRIGEN 2
`define UMCL_MCTL_RTS 1
`define UMCL_MCTL_DTR 0
`define UMCL_MCTL_GATED_MASK 8'he4
`define UMCL_MCTL_WR_MASK 8'hf7
`define UMCL_FEAT_WREN 4
`define UMCL_CHAR_W 8
`define UMCL_FLAG_W 3
`define UMCL_FLAG_LSB 8
`define UMCL_PRESCALE_DIV 2'h3
`define UMCL_FIFO_DEPTH 8
`define UMCL_FIFO_AW 3
`endif

// ### verilog/umcl_prescaler.v
// clock prescaler producing a baud-rate enable pulse, divide by one or four
`timescale 1ns/10ps
`default_nettype none
`include "umcl_consts.vh"
module umcl_prescaler
(
  input wire sys_clk,
  input wire srst,
  input wire div4,
  output reg tick
);
  reg [1:0] cnt;
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      cnt <= 2'h0;
      tick <= 1'b0;
    end
    else if (!div4)
    begin
      cnt <= 2'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      tick <= (cnt == `UMCL_PRESCALE_DIV);
    end
  end
endmodule
`default_nettype wire

// ### verilog/umcl_fifo.v
// receive fifo holding a character with its error flags, flip-flop storage
`timescale 1ns/10ps
`default_nettype none
`include "umcl_consts.vh"
module umcl_fifo
#(
  parameter WIDTH = 11,
  parameter DEPTH = `UMCL_FIFO_DEPTH,
  parameter AW = `UMCL_FIFO_AW
)
(
  input wire sys_clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [DEPTH-1:0] slot_used,
  output wire [DEPTH*WIDTH-1:0] slot_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  localparam [AW:0] FULL = DEPTH;
  assign in_ready = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : slots
      localparam [AW-1:0] SLOT = g;
      wire [AW-1:0] off;
      assign off = SLOT - rd_ptr;
      assign slot_used[g] = ({1'b0, off} < count);
      assign slot_data[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate
  always @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### sim/umcl_checker.sv
// assertion checker for the modem control and line status ports
`timescale 1ns/10ps
`default_nettype none
module umcl_checker
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic feat_wr_en,
  input wire logic tx_hold_empty,
  input wire logic tx_shift_empty,
  input wire logic tx_serial,
  input wire logic rx_pin,
  input wire logic rx_serial,
  input wire logic cts_status,
  input wire logic dsr_status_loop,
  input wire logic auto_rts_en,
  input wire logic auto_rts_n,
  input wire logic rts_n_pin,
  input wire logic dtr_pin_sel,
  input wire logic pin_level_dtr,
  input wire logic dtr_n_pin,
  input wire logic ir_mode,
  input wire logic xon_any,
  input wire logic trig_regs_en,
  input wire logic loopback,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ========================================
  // port relations, mode pins settle two cycles after a write
  logic mw;
  assign mw = reg_wr && reg_addr == 3'h4;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_MODES:
  assert property (mw && feat_wr_en |=> ##1 {ir_mode, xon_any, trig_regs_en} ==
    {$past(reg_wdata[6], 2), $past(reg_wdata[5], 2), $past(reg_wdata[2], 2)}) else $error("modes");
  AST_GATE:
  assert property (mw && !feat_wr_en |=> ##1 $stable({ir_mode, xon_any, trig_regs_en}))
    else $error("gated bits moved");
  AST_LOOP:
  assert property (mw |=> ##1 loopback == $past(reg_wdata[4], 2)) else $error("loopback");
  AST_RXPATH:
  assert property (!$past(srst) |-> rx_serial == (loopback ? $past(tx_serial) : $past(rx_pin)))
    else $error("rx path");
  AST_LOOPSTAT:
  assert property (mw && reg_wdata[4] |=> ##1 {cts_status, dsr_status_loop} ==
    $past(reg_wdata[1:0], 2)) else $error("loop status");
  AST_RTS:
  assert property (mw && !reg_wdata[4] && !auto_rts_en ##1 !auto_rts_en |=>
    rts_n_pin == !$past(reg_wdata[1], 2)) else $error("rts");
  AST_DTR:
  assert property (mw && !reg_wdata[4] && dtr_pin_sel ##1 dtr_pin_sel |=>
    dtr_n_pin == !$past(reg_wdata[0], 2)) else $error("dtr");
  AST_TXEMPTY:
  assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata[6:5] ==
    {$past(tx_hold_empty && tx_shift_empty), $past(tx_hold_empty)}) else $error("tx empty");
  AST_AUTORTS:
  assert property (auto_rts_en |=> loopback || rts_n_pin == $past(auto_rts_n))
    else $error("auto rts");
  AST_DTRFREE:
  assert property (!dtr_pin_sel |=> loopback || dtr_n_pin == $past(pin_level_dtr))
    else $error("dtr pin level");
endmodule
bind umcl_top umcl_checker chk (.*);
`default_nettype wire

// ### sim/umcl_line_partner.sv
// far-side line model: receive line and clear-to-send pin
`timescale 1ns/10ps
`default_nettype none
module umcl_line_partner
(
  input wire logic sys_clk,
  input wire logic send,
  output logic rx_pin = 1'b1,
  output logic cts_n_pin = 1'b1
);
  // ========================================
  // line drive
  // marking level between frames; alternating bits show every stale sample
  always @(posedge sys_clk)
  begin
    rx_pin <= send ? ~rx_pin : 1'b1;
    cts_n_pin <= ~send;
  end
endmodule
`default_nettype wire

// ### sim/umcl_top_tb.sv
// self-checking bench of the modem control and line status block
`timescale 1ns/10ps
`default_nettype none
module umcl_top_tb;
  // ========================================
  // stimulus, reference model and checks
  logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, feat_wr_en = 0, rx_hold_rd = 0;
  logic rx_char_valid = 0, rx_break = 0, rx_framing = 0, rx_parity = 0, tx_hold_empty = 0;
  logic tx_shift_empty = 0;
  logic tx_serial = 1, auto_rts_en = 0, auto_rts_n = 1, dtr_pin_sel = 1, pin_level_dtr = 0;
  logic send = 0, rd_q = 0, pop_q = 0, ovr = 0, rx_pin, cts_n_pin, rx_serial, cts_status;
  logic dsr_status_loop, rts_n_pin, dtr_n_pin, baud_tick, ir_mode, xon_any, trig_regs_en, loopback;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, rx_char = 0, reg_rdata, rx_hold_data, mctl = 0, e, qr[$], qh[$];
  logic [10:0] mq[$];
  logic [31:0] r, seed = 32'h164d9;
  int mismatches = 0, tests_run = 0, cyc = 0, ticks = 0, t0;
  always #50 sys_clk = ~sys_clk;
  umcl_top dut (.*);
  umcl_line_partner line (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // model keeps mode bits 7, 6, 5 and 2 unless the enhanced write enable is up
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic en);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata, feat_wr_en} = {1'b1, a, d, en};
    if (a == 3'h4)
      mctl = en ? d & 8'hf7 : (mctl & 8'he4) | (d & 8'h13);
    @(negedge sys_clk);
    reg_wr = 0;
  endtask
  task automatic op(input logic [2:0] a, input logic p);
    @(negedge sys_clk);
    r = rnd();
    {reg_rd, reg_addr, tx_hold_empty, tx_shift_empty} = {1'b1, a, r[1:0]};
    e = 0;
    foreach (mq[i]) e[7] |= |mq[i][10:8];
    e[6:0] = {r[1] & r[0], r[1], mq.size() ? mq[0][10:8] : 3'h0, ovr, mq.size() > 0};
    qr.push_back(a == 3'h5 ? e : a == 3'h4 ? mctl : 8'h00);
    ovr = a == 3'h5 ? 1'b0 : ovr;
    @(negedge sys_clk);
    // a pop of an empty fifo has no result to compare, so none is asked for
    {reg_rd, rx_hold_rd} = {1'b0, p && mq.size() > 0};
    if (rx_hold_rd)
    begin
      qh.push_back(mq[0][7:0]);
      mq.delete(0);
    end
    @(negedge sys_clk);
    rx_hold_rd = 0;
  endtask
  task automatic ps(input logic [10:0] v);
    @(negedge sys_clk);
    {rx_char_valid, rx_break, rx_framing, rx_parity} = {1'b1, v[10:8]};
    rx_char = v[10] ? 8'h00 : v[7:0];
    if (mq.size() < 8)
      mq.push_back({v[10:8], rx_char});
    else
      ovr = 1;
    @(negedge sys_clk);
    rx_char_valid = 0;
  endtask
  always @(posedge sys_clk)
  begin
    {rd_q, pop_q} <= {reg_rd, rx_hold_rd};
    cyc <= cyc + 1;
    ticks <= ticks + (baud_tick === 1'b1);
  end
  always @(negedge sys_clk)
  begin
    if (rd_q)
      chk(reg_rdata, qr.pop_front());
    if (pop_q)
      chk(rx_hold_data, qh.pop_front());
    if (cyc == 4000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 0;
    op(3'h4, 0);
    wr(3'h4, 8'hff, 0);
    op(3'h4, 0);
    wr(3'h5, 8'hff, 1);
    op(3'h0, 0);
    repeat (6)
    begin
      r = rnd();
      {auto_rts_en, auto_rts_n, dtr_pin_sel, pin_level_dtr} = r[12:9];
      wr(3'h4, r[7:0] & 8'hef, r[8]);
      op(3'h4, 0);
    end
    {auto_rts_en, dtr_pin_sel} = 2'b01;
    for (int j = 0; j < 2; j++)
    begin
      wr(3'h4, {j[0], 7'h00}, 1);
      repeat (4) @(negedge sys_clk);
      t0 = ticks;
      repeat (40) @(negedge sys_clk);
      chk(8'(ticks - t0), j ? 8'h0a : 8'h28);
    end
    wr(3'h4, 8'h13, 0);
    send = 1;
    repeat (20)
    begin
      @(negedge sys_clk);
      r = rnd();
      tx_serial = r[0];
    end
    send = 0;
    wr(3'h4, 8'h03, 0);
    ps(11'h05a);
    ps(11'h477);
    ps(11'h231);
    ps(11'h1c3);
    repeat (5) op(3'h5, 1);
    repeat (9)
    begin
      r = rnd();
      ps(r[10:0]);
    end
    repeat (2) op(3'h5, 0);
    repeat (8) op(3'h5, 1);
    repeat (3) @(negedge sys_clk);
    stop_test();
  end
endmodule
`default_nettype wire
